// ---- rtl/dac_serial_pkg.sv ----
package dac_serial_pkg;

  // serial word layout, msb first
  localparam int WORD_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int RW_BIT    = 23;
  localparam int REG_MSB   = 21;
  localparam int REG_LSB   = 19;
  localparam int ADDR_MSB  = 18;
  localparam int ADDR_LSB  = 16;

  // register select and channel address codes
  localparam logic [2:0] REG_DAC   = 3'h0;
  localparam logic [2:0] ADDR_A    = 3'h0;
  localparam logic [2:0] ADDR_B    = 3'h2;
  localparam logic [2:0] ADDR_BOTH = 3'h4;

  // codes
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_HALF = 16'h8000;

  // falling serial clock edges per frame, and the saturation point
  localparam logic [4:0] EDGE_TARGET = 5'h18;
  localparam logic [4:0] EDGE_LIMIT  = 5'h19;

  // pin vector positions
  localparam int PIN_FS    = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_SDI   = 2;
  localparam int PIN_LOAD  = 3;
  localparam int PIN_CLEAR = 4;
  localparam int PIN_COUNT = 5;
  localparam logic [4:0] PIN_IDLE = 5'h1b;

  // serial clock ceiling against the sampling clock
  localparam int SCLK_MAX_MHZ = 30;
  localparam int CLK_MHZ      = 250;
  localparam int SCLK_MIN_CYCLES = CLK_MHZ / SCLK_MAX_MHZ;

endpackage

// ---- rtl/dual_dac_serial_load_interface.sv ----
// Behaviour
// (R1) while frame sync is low, shift one input bit per falling serial clock edge
// (R2) rising frame sync ends the frame and captures the word into the addressed register
// (R3) host holds serial input stable at each falling serial clock edge
// (R4) serial clock runs no faster than 30 MHz
// (R5) load strobe low: addressed output register updates at frame sync rise
// (R6) load strobe high during write: input register only, output waits for strobe fall
// (R7) load strobe fall moves pending values of both channels to outputs together
// (R8) clear low forces registers to zero-scale or midscale by user setting
// (R9) serial output bit changes on rising serial clock edges
// (R10) receiver samples serial output on the falling serial clock edge
// (R11) bipolar: format pin high offset binary, low twos complement; unipolar straight
// (R12) 0x8000 straight or 0x0000 twos complement is the bipolar zero code
// (R13) 0x0000 straight or 0x8000 twos complement is the zero-scale code
// (R14) 24-bit word msb first: rw, one zero bit, three select, three address, sixteen data
// (R15) exactly 24 falling edges per frame, otherwise the frame is discarded
// (R16) power-on reset loads all converter registers with 0x0000
// (R17) clear acts at once, independent of serial clock, over any pending update
`timescale 1ns/1ps
`default_nettype none

module dual_dac_serial_load_interface (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        frame_sync_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_in_line,
  input  wire logic        load_outputs_n,
  input  wire logic        clear_registers_n,
  input  wire logic        code_format_select,
  input  wire logic        clear_to_midscale,
  input  wire logic        bipolar_range,
  output logic             serial_out_line,
  output logic [15:0]      dac_a_code,
  output logic [15:0]      dac_b_code,
  output logic [15:0]      dac_a_level,
  output logic [15:0]      dac_b_level,
  output logic             frame_done,
  output logic             frame_error
);

  // each serial clock period must outlast the synchroniser and the edge detector
  if (dac_serial_pkg::SCLK_MIN_CYCLES < 4) begin : g_rate_check
    $error("sampling clock too slow for the serial clock ceiling");
  end

  // raw code to offset-binary level for the analog string
  function automatic logic [15:0] to_level(input logic [15:0] code, input logic bip,
                                           input logic fmt);
    if (bip && !fmt) begin // (R11)
      to_level = {~code[15], code[14:0]};
    end else begin
      to_level = code;
    end
  endfunction

  // clear target as a raw code in the active format
  function automatic logic [15:0] clear_code(input logic mid, input logic bip,
                                             input logic fmt);
    logic twos;
    twos = bip && !fmt;
    if (mid) begin // (R12)
      clear_code = twos ? dac_serial_pkg::CODE_ZERO : dac_serial_pkg::CODE_HALF;
    end else begin // (R13)
      clear_code = twos ? dac_serial_pkg::CODE_HALF : dac_serial_pkg::CODE_ZERO;
    end
  endfunction

  localparam int NP = dac_serial_pkg::PIN_COUNT;

  // pin synchronisers: a change counts once stages two and three agree
  logic [NP-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [NP-1:0] s1_next, s2_next, s3_next, pin_next;

  always_comb begin
    s1_next = {clear_registers_n, load_outputs_n, serial_in_line, serial_clk, frame_sync_n};
    s2_next = s1_reg;
    s3_next = s2_reg;
    for (int i = 0; i < NP; i++) begin
      pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg  <= dac_serial_pkg::PIN_IDLE;
      s2_reg  <= dac_serial_pkg::PIN_IDLE;
      s3_reg  <= dac_serial_pkg::PIN_IDLE;
      pin_reg <= dac_serial_pkg::PIN_IDLE;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      pin_reg <= pin_next;
    end
  end

  logic fs_fall, fs_rise, sclk_fall, sclk_rise, load_fall, clear_low, in_frame;

  always_comb begin
    fs_fall   = pin_reg[dac_serial_pkg::PIN_FS] && !pin_next[dac_serial_pkg::PIN_FS];
    fs_rise   = !pin_reg[dac_serial_pkg::PIN_FS] && pin_next[dac_serial_pkg::PIN_FS];
    sclk_fall = pin_reg[dac_serial_pkg::PIN_SCLK] && !pin_next[dac_serial_pkg::PIN_SCLK];
    sclk_rise = !pin_reg[dac_serial_pkg::PIN_SCLK] && pin_next[dac_serial_pkg::PIN_SCLK];
    load_fall = pin_reg[dac_serial_pkg::PIN_LOAD] && !pin_next[dac_serial_pkg::PIN_LOAD];
    clear_low = !pin_next[dac_serial_pkg::PIN_CLEAR];
    in_frame  = !pin_reg[dac_serial_pkg::PIN_FS];
  end

  // serial engine and converter registers
  logic [23:0] shift_reg, shift_next;
  logic [4:0]  edges_reg, edges_next;
  logic [15:0] in_a_reg, in_a_next, in_b_reg, in_b_next;
  logic [15:0] out_a_reg, out_a_next, out_b_reg, out_b_next;
  logic [15:0] lvl_a_reg, lvl_a_next, lvl_b_reg, lvl_b_next;
  logic        pend_reg, pend_next, sout_reg, sout_next;
  logic        done_reg, done_next, err_reg, err_next;
  logic        wr_a, wr_b, word_ok;
  logic [2:0]  sel, addr;
  logic [15:0] clear_val;

  always_comb begin
    shift_next = shift_reg;
    edges_next = edges_reg;
    in_a_next  = in_a_reg;
    in_b_next  = in_b_reg;
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    pend_next  = pend_reg;
    sout_next  = sout_reg;
    done_next  = 1'b0;
    err_next   = 1'b0;
    sel        = shift_reg[dac_serial_pkg::REG_MSB:dac_serial_pkg::REG_LSB];
    addr       = shift_reg[dac_serial_pkg::ADDR_MSB:dac_serial_pkg::ADDR_LSB];
    word_ok    = (edges_reg == dac_serial_pkg::EDGE_TARGET); // (R15)
    wr_a       = 1'b0;
    wr_b       = 1'b0;
    clear_val  = clear_code(clear_to_midscale, bipolar_range, code_format_select);

    if (fs_fall) begin
      edges_next = 5'h00;
      sout_next  = shift_reg[dac_serial_pkg::WORD_BITS-1];
    end else if (in_frame && sclk_fall) begin
      // msb first, so the oldest bit leaves at the top
      shift_next = {shift_reg[22:0], pin_reg[dac_serial_pkg::PIN_SDI]}; // (R1) (R14)
      if (edges_reg != dac_serial_pkg::EDGE_LIMIT) begin
        edges_next = edges_reg + 5'h01;
      end
    end else if (in_frame && sclk_rise) begin
      sout_next = shift_reg[dac_serial_pkg::WORD_BITS-1]; // (R9)
    end

    if (fs_rise) begin // (R2)
      done_next = word_ok;
      err_next  = !word_ok;
      if (word_ok && sel == dac_serial_pkg::REG_DAC) begin
        if (shift_reg[dac_serial_pkg::RW_BIT]) begin
          // readback word goes out in the next frame
          shift_next = {8'h00, (addr == dac_serial_pkg::ADDR_B) ? out_b_reg : out_a_reg};
        end else begin
          wr_a = (addr == dac_serial_pkg::ADDR_A) || (addr == dac_serial_pkg::ADDR_BOTH);
          wr_b = (addr == dac_serial_pkg::ADDR_B) || (addr == dac_serial_pkg::ADDR_BOTH);
        end
      end
    end

    if (wr_a) begin
      in_a_next = shift_reg[15:0];
    end
    if (wr_b) begin
      in_b_next = shift_reg[15:0];
    end
    if (wr_a || wr_b) begin
      if (!pin_reg[dac_serial_pkg::PIN_LOAD]) begin // (R5)
        if (wr_a) begin
          out_a_next = shift_reg[15:0];
        end
        if (wr_b) begin
          out_b_next = shift_reg[15:0];
        end
      end else begin
        pend_next = 1'b1; // (R6)
      end
    end

    // with nothing pending the input registers already match the outputs
    if (load_fall && pend_next) begin // (R7)
      out_a_next = in_a_next;
      out_b_next = in_b_next;
      pend_next  = 1'b0;
    end

    // clear overrides any update landing in the same cycle
    if (clear_low) begin // (R8) (R17)
      in_a_next  = clear_val;
      in_b_next  = clear_val;
      out_a_next = clear_val;
      out_b_next = clear_val;
      pend_next  = 1'b0;
    end

    lvl_a_next = to_level(out_a_next, bipolar_range, code_format_select); // (R11)
    lvl_b_next = to_level(out_b_next, bipolar_range, code_format_select);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin // (R16)
      shift_reg <= 24'h000000;
      edges_reg <= 5'h00;
      in_a_reg  <= dac_serial_pkg::CODE_ZERO;
      in_b_reg  <= dac_serial_pkg::CODE_ZERO;
      out_a_reg <= dac_serial_pkg::CODE_ZERO;
      out_b_reg <= dac_serial_pkg::CODE_ZERO;
      lvl_a_reg <= dac_serial_pkg::CODE_ZERO;
      lvl_b_reg <= dac_serial_pkg::CODE_ZERO;
      pend_reg  <= 1'b0;
      sout_reg  <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      edges_reg <= edges_next;
      in_a_reg  <= in_a_next;
      in_b_reg  <= in_b_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      lvl_a_reg <= lvl_a_next;
      lvl_b_reg <= lvl_b_next;
      pend_reg  <= pend_next;
      sout_reg  <= sout_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
    end
  end

  assign serial_out_line = sout_reg;
  assign dac_a_code      = out_a_reg;
  assign dac_b_code      = out_b_reg;
  assign dac_a_level     = lvl_a_reg;
  assign dac_b_level     = lvl_b_reg;
  assign frame_done      = done_reg;
  assign frame_error     = err_reg;

endmodule // dual_dac_serial_load_interface

`default_nettype wire

// ---- tb/dac_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        frame_sync_n,
  input wire logic        serial_clk,
  input wire logic        load_outputs_n,
  input wire logic        clear_registers_n,
  input wire logic        code_format_select,
  input wire logic        clear_to_midscale,
  input wire logic        bipolar_range,
  input wire logic        serial_out_line,
  input wire logic [15:0] dac_a_code,
  input wire logic [15:0] dac_b_code,
  input wire logic [15:0] dac_a_level,
  input wire logic [15:0] dac_b_level,
  input wire logic        frame_done,
  input wire logic        frame_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic        twos;
  logic [15:0] clear_exp;
  assign twos      = bipolar_range & ~code_format_select;
  assign clear_exp = {clear_to_midscale ^ twos, 15'h0};
  property p_keep; frame_error && clear_registers_n |-> $stable({dac_a_code, dac_b_code});
  endproperty
  a_keep: assert property (p_keep) else $error("bad frame changed a code");
  property p_end; frame_done || frame_error |-> frame_sync_n && $past(frame_sync_n, 3)
    && !$past(frame_sync_n, 8); endproperty
  a_end: assert property (p_end) else $error("frame result without frame end");
  property p_clear; !clear_registers_n [*8] |-> dac_a_code == clear_exp
    && dac_b_code == clear_exp; endproperty
  a_clear: assert property (p_clear) else $error("clear code wrong");
  property p_lva; $changed(dac_a_code) |-> dac_a_level == (dac_a_code ^ {twos, 15'h0});
  endproperty
  a_lva: assert property (p_lva) else $error("level a wrong");
  property p_lvb; $changed(dac_b_code) |-> dac_b_level == (dac_b_code ^ {twos, 15'h0});
  endproperty
  a_lvb: assert property (p_lvb) else $error("level b wrong");
  property p_hold; frame_done && load_outputs_n && $past(load_outputs_n, 8)
    |-> $stable({dac_a_code, dac_b_code}); endproperty
  a_hold: assert property (p_hold) else $error("output moved with load high");
  property p_cause; $changed({dac_a_code, dac_b_code}) && clear_registers_n
    && $past(clear_registers_n, 8) |-> frame_done || !$past(load_outputs_n, 3); endproperty
  a_cause: assert property (p_cause) else $error("code moved without cause");
  property p_sout; $changed(serial_out_line) |-> $past(serial_clk, 3)
    || $past(frame_sync_n, 3); endproperty
  a_sout: assert property (p_sout) else $error("serial out moved in clock low");
endmodule // dac_chk
`default_nettype wire

// ---- tb/dual_dac_serial_load_interface_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_load_interface_tb_top;
  logic        clk, sys_rst, frame_sync_n, serial_clk, serial_in_line, serial_out_line;
  logic        load_outputs_n, clear_registers_n, code_format_select, clear_to_midscale;
  logic        bipolar_range, frame_done, frame_error;
  logic [15:0] dac_a_code, dac_b_code, dac_a_level, dac_b_level, ia, ib, ma, mb;
  logic [23:0] rd, w;
  int          errors, tests_run, dones, errs, e0;
  integer      seed;
  dual_dac_serial_load_interface i_dual_dac_serial_load_interface (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .frame_sync_n       (frame_sync_n),
    .serial_clk         (serial_clk),
    .serial_in_line     (serial_in_line),
    .load_outputs_n     (load_outputs_n),
    .clear_registers_n  (clear_registers_n),
    .code_format_select (code_format_select),
    .clear_to_midscale  (clear_to_midscale),
    .bipolar_range      (bipolar_range),
    .serial_out_line    (serial_out_line),
    .dac_a_code         (dac_a_code),
    .dac_b_code         (dac_b_code),
    .dac_a_level        (dac_a_level),
    .dac_b_level        (dac_b_level),
    .frame_done         (frame_done),
    .frame_error        (frame_error)
  );
  host_model i_host_model (
    .clk             (clk),
    .serial_out_line (serial_out_line),
    .frame_sync_n    (frame_sync_n),
    .serial_clk      (serial_clk),
    .serial_in_line  (serial_in_line)
  );
  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (frame_done === 1'b1) dones++;
    if (frame_error === 1'b1) errs++;
  end
  function automatic logic [15:0] lvl(input logic [15:0] c);
    return c ^ {bipolar_range & ~code_format_select, 15'h0};
  endfunction
  function automatic logic [15:0] clrc();
    return {clear_to_midscale ^ (bipolar_range & ~code_format_select), 15'h0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    int d0;
    d0 = dones;
    w = {2'h0, dac_serial_pkg::REG_DAC, a, d};
    i_host_model.send(w, 24, rd);
    if (a != dac_serial_pkg::ADDR_B) ia = d;
    if (a != dac_serial_pkg::ADDR_A) ib = d;
    {ma, mb} = load_outputs_n ? {ma, mb} : {ia, ib};
    chk("done", d0 + 1, dones);
    chk("codes", {ma, mb}, {dac_a_code, dac_b_code});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    {errors, tests_run, dones, errs} = '0;
    seed = 32'h630aab09;
    {sys_rst, load_outputs_n, clear_registers_n, code_format_select} = 4'hf;
    {clear_to_midscale, bipolar_range, ma, mb} = '0;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    chk("reset", 32'h0, {dac_a_code, dac_b_code});
    load_outputs_n = 1'b0;
    for (int i = 0; i < 9; i++) begin
      // settings change only before a write to both, so no level goes stale
      // the first pass forces bipolar twos complement so both coding corners are hit
      if (i == 0) {code_format_select, bipolar_range} = 2'b01;
      else if (i % 3 == 0) {code_format_select, bipolar_range} = 2'($random(seed));
      wr(i % 3 == 0 ? dac_serial_pkg::ADDR_BOTH : i % 3 == 1 ? dac_serial_pkg::ADDR_A :
         dac_serial_pkg::ADDR_B, i < 2 ? {i[0] ^ 1'b1, 15'h0} : 16'($random(seed)));
      chk("levels", {lvl(ma), lvl(mb)}, {dac_a_level, dac_b_level});
    end
    load_outputs_n = 1'b1;
    wr(dac_serial_pkg::ADDR_A, 16'($random(seed)));
    wr(dac_serial_pkg::ADDR_B, 16'($random(seed)));
    load_outputs_n = 1'b0;
    {ma, mb} = {ia, ib};
    repeat (10) @(negedge clk);
    chk("loaded", {ma, mb}, {dac_a_code, dac_b_code});
    for (int n = 23; n <= 25; n += 2) begin
      e0 = errs;
      i_host_model.send({2'h0, dac_serial_pkg::REG_DAC, dac_serial_pkg::ADDR_BOTH, 16'h5a5a},
                        n, rd);
      chk("error", e0 + 1, errs);
      chk("kept", {ma, mb}, {dac_a_code, dac_b_code});
    end
    wr(dac_serial_pkg::ADDR_B, 16'($random(seed)));
    i_host_model.send({1'b1, 1'b0, dac_serial_pkg::REG_DAC, dac_serial_pkg::ADDR_B, 16'h0},
                      24, rd);
    chk("chain", w, rd);
    i_host_model.send({2'h0, 3'h7, 19'h0}, 24, rd);
    chk("readback", {8'h0, mb}, rd);
    // bipolar twos complement swaps the two clear targets
    {code_format_select, bipolar_range} = 2'b01;
    for (int m = 0; m < 2; m++) begin
      clear_to_midscale = m[0];
      clear_registers_n = 1'b0;
      // a write inside the clear must lose to it
      i_host_model.send({2'h0, dac_serial_pkg::REG_DAC, dac_serial_pkg::ADDR_BOTH, 16'h1234},
                        24, rd);
      chk("clear", {clrc(), clrc()}, {dac_a_code, dac_b_code});
      clear_registers_n = 1'b1;
      repeat (10) @(negedge clk);
    end
    finish_test();
  end
endmodule // dual_dac_serial_load_interface_tb_top
bind dual_dac_serial_load_interface dac_chk i_dac_chk (
  .clk                (clk),
  .sys_rst            (sys_rst),
  .frame_sync_n       (frame_sync_n),
  .serial_clk         (serial_clk),
  .load_outputs_n     (load_outputs_n),
  .clear_registers_n  (clear_registers_n),
  .code_format_select (code_format_select),
  .clear_to_midscale  (clear_to_midscale),
  .bipolar_range      (bipolar_range),
  .serial_out_line    (serial_out_line),
  .dac_a_code         (dac_a_code),
  .dac_b_code         (dac_b_code),
  .dac_a_level        (dac_a_level),
  .dac_b_level        (dac_b_level),
  .frame_done         (frame_done),
  .frame_error        (frame_error)
);
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk,
  input  wire logic serial_out_line,
  output var logic  frame_sync_n,
  output var logic  serial_clk,
  output var logic  serial_in_line
);
  initial begin
    frame_sync_n   = 1'b1;
    serial_clk     = 1'b1;
    serial_in_line = 1'b0;
  end
  // clock idles high and only moves inside a frame
  task automatic send(input logic [23:0] w, input int n, output logic [23:0] rd);
    rd = 24'h0;
    frame_sync_n = 1'b0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      serial_in_line = w[23];
      w = {w[22:0], w[23]};
      repeat (10) @(negedge clk);
      rd = {rd[22:0], serial_out_line};
      serial_clk = 1'b0;
      repeat (10) @(negedge clk);
      serial_clk = 1'b1;
    end
    repeat (10) @(negedge clk);
    frame_sync_n = 1'b1;
    // no pull on the data line, so never leave the last bit standing
    serial_in_line = ~serial_in_line;
    repeat (60) @(negedge clk);
  endtask
endmodule // host_model
`default_nettype wire
